// ---- psp_pin_state.sv ----
// Notes on behaviour
// R1: Standby pin state chosen by level bit
// R2: External reset low is separate phase
// R3: Hi-Z turns output drive off
// R4: Blocked input reads constant low
// R5: GPIO keeps last output in run/standby
// R6: Held peripheral pin follows running peripheral
// R7: Level bit 1: GPIO Hi-Z, input low
// R8: Oscillator and mode inputs always enabled; code blocks the mode-shared GPIO input in the reset phases
// R9: Reset pin keeps pull-up and input
// R10: Main osc output Hi-Z once stopped
// R11: Sub osc output Hi-Z only in stop
// R12: Osc output Hi-Z, input low in reset
// R13: Interrupt pins hold in all standby
// R14: Analog input pins Hi-Z, analog path on; code keeps the analog path off in power-on
// R15: Analog output, bit 0: input low later
// R16: Analog output, bit 1: Hi-Z later
// R17: Reset phases ignore disabled function settings
// R18: Resource pins Hi-Z with input in reset; code blocks the input in power-on
// R19: Mode-shared GPIO keeps input in standby
// R20: Capture level bit on standby entry
//
// Purpose: Pin state control across reset, run and standby phases
// Assumes: Power and reset controllers are asynchronous pins
// Notes:   Every output is registered; pins work through one cell each
`timescale 1ns/10ps
`default_nettype none
module psp_pin_state
  import psp_pkg::*;
(
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_rst,
  input  wire logic                      i_por_active,
  input  wire logic                      i_external_reset_pin,
  input  wire logic                      i_int_reset,
  input  wire logic                      i_standby_req,
  input  wire psp_sbmode_e               i_standby_mode,
  input  wire logic                      i_standby_pin_level_select,
  input  wire logic                      i_main_osc_run,
  input  wire logic                      i_sub_osc_run,
  input  wire psp_cfg_s [`PSP_NPINS-1:0] i_cfg,
  input  wire logic [`PSP_NPINS-1:0]     i_fn_out,
  input  wire logic [`PSP_NPINS-1:0]     i_fn_oe,
  input  wire logic [`PSP_NPINS-1:0]     i_periph_live,
  input  wire logic [`PSP_NPINS-1:0]     i_pad_in,
  output psp_pad_s [`PSP_NPINS-1:0]      o_pad,
  output logic [`PSP_NPINS-1:0]          o_core_in,
  output logic                           o_xrst_pu,
  output logic                           o_xrst_ie,
  output logic                           o_xrst_level,
  output psp_phase_e                     o_phase,
  output logic                           o_level_held
);
  import psp_pkg::*;

  logic [`PSP_NPINS-1:0] pad_meta;
  logic [`PSP_NPINS-1:0] pad_sync;
  logic [4:0]            ctl_meta;
  logic [4:0]            ctl_sync;
  psp_sbmode_e           sbmode;
  psp_phase_e            next_phase;

  // Two-stage synchronisers for pins and controller levels
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      pad_meta <= '0;
      pad_sync <= '0;
      ctl_meta <= 5'h02;
      ctl_sync <= 5'h02;
    end else begin
      pad_meta <= i_pad_in;
      pad_sync <= pad_meta;
      ctl_meta <= {i_standby_req, i_int_reset, i_external_reset_pin,
                   i_por_active, i_standby_pin_level_select};
      ctl_sync <= ctl_meta;
    end
  end

  // Phase priority: power-on, reset pin low, internal reset, standby
  always_comb begin
    if (ctl_sync[1]) begin
      next_phase = PSP_PH_POR;
    end else if (!ctl_sync[2]) begin
      next_phase = PSP_PH_XRST; // R2
    end else if (ctl_sync[3]) begin
      next_phase = PSP_PH_IRST; // R2
    end else if (ctl_sync[4]) begin
      next_phase = PSP_PH_STBY;
    end else begin
      next_phase = PSP_PH_RUN;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_phase <= PSP_PH_POR;
    end else begin
      o_phase <= next_phase;
    end
  end

  // Level bit and mode are sampled only at standby entry so a change in
  // the control register during standby cannot flip pins mid-sleep
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_level_held <= `PSP_LEVEL_RST;
      sbmode       <= PSP_SB_TIMER;
    end else if (next_phase == PSP_PH_STBY && o_phase != PSP_PH_STBY) begin
      o_level_held <= ctl_sync[0]; // R1 R20
      sbmode       <= i_standby_mode;
    end
  end

  // Reset pin pad: pull-up and input in every phase
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_xrst_pu    <= 1'b1;
      o_xrst_ie    <= 1'b1;
      o_xrst_level <= 1'b1;
    end else begin
      o_xrst_pu    <= 1'b1; // R9
      o_xrst_ie    <= 1'b1; // R9
      o_xrst_level <= ctl_sync[2];
    end
  end

  // One cell per pin
  genvar g;
  generate
    for (g = 0; g < `PSP_NPINS; g++) begin : g_pin
      psp_pin_cell u_cell (
        .i_clk_sys      (i_clk_sys),
        .i_rst          (i_rst),
        .i_phase        (o_phase),
        .i_sbmode       (sbmode),
        .i_level_sel    (o_level_held),
        .i_main_osc_run (i_main_osc_run),
        .i_sub_osc_run  (i_sub_osc_run),
        .i_cfg          (i_cfg[g]),
        .i_fn_out       (i_fn_out[g]),
        .i_fn_oe        (i_fn_oe[g]),
        .i_periph_live  (i_periph_live[g]),
        .i_pad_in       (pad_sync[g]),
        .o_pad          (o_pad[g]),
        .o_core_in      (o_core_in[g])
      );
    end
  endgenerate

  // Assertions
  property p_pullup;
    @(posedge i_clk_sys) disable iff (i_rst) o_xrst_pu && o_xrst_ie;
  endproperty
  a_pullup: assert property (p_pullup) else $error("reset pin pull-up lost"); // R9

  property p_xrst_phase;
    @(posedge i_clk_sys) disable iff (i_rst)
      (!ctl_sync[1] && !ctl_sync[2]) |=> (o_phase == PSP_PH_XRST);
  endproperty
  a_xrst_phase: assert property (p_xrst_phase) else $error("reset pin phase"); // R2

  property p_level_cap;
    @(posedge i_clk_sys) disable iff (i_rst)
      (next_phase == PSP_PH_STBY && o_phase != PSP_PH_STBY) |=>
        o_level_held == $past(ctl_sync[0]);
  endproperty
  a_level_cap: assert property (p_level_cap) else $error("level bit not captured"); // R20

  property p_in_low;
    @(posedge i_clk_sys) disable iff (i_rst)
      !o_pad[0].ie |-> !o_core_in[0];
  endproperty
  a_in_low: assert property (p_in_low) else $error("blocked input not low"); // R4

  property p_hiz;
    @(posedge i_clk_sys) disable iff (i_rst)
      (o_phase == PSP_PH_POR && i_cfg[0].func == PSP_FN_GPIO) |=> !o_pad[0].oe;
  endproperty
  a_hiz: assert property (p_hiz) else $error("pin driven in power-on"); // R3

  // Pin 1 carries a general resource; with level bit 1 it must let go of the pad
  property p_periph_level1;
    @(posedge i_clk_sys) disable iff (i_rst)
      (o_phase == PSP_PH_STBY && o_level_held && !i_cfg[1].mode_share &&
       (i_cfg[1].func == PSP_FN_GPIO || i_cfg[1].func == PSP_FN_PERIPH)) |=>
        (!o_pad[1].oe && !o_core_in[1]);
  endproperty
  a_periph_level1: assert property (p_periph_level1) else $error("pin not released"); // R7

  // Edge of reset release skipped: pads still show their reset value one cycle on
  property p_oscin;
    @(posedge i_clk_sys) disable iff (i_rst)
      (!$past(i_rst) && i_cfg[2].func == PSP_FN_OSCIN) |=> o_pad[2].ie;
  endproperty
  a_oscin: assert property (p_oscin) else $error("osc input blocked"); // R8

  property p_gpio_hold;
    @(posedge i_clk_sys) disable iff (i_rst)
      (o_phase == PSP_PH_STBY && !o_level_held && i_cfg[0].func == PSP_FN_GPIO &&
       !i_periph_live[0]) |=> o_pad[0].out == $past(o_pad[0].out) || $past(o_phase) != PSP_PH_STBY;
  endproperty
  a_gpio_hold: assert property (p_gpio_hold) else $error("GPIO not held"); // R5

  c_stby: cover property (@(posedge i_clk_sys) o_phase == PSP_PH_STBY);
  c_xrst: cover property (@(posedge i_clk_sys) o_phase == PSP_PH_XRST);
  c_level1: cover property (@(posedge i_clk_sys) o_phase == PSP_PH_STBY && o_level_held);
endmodule : psp_pin_state
`default_nettype wire

// ---- psp_defines.svh ----
// Purpose: Constants for the pin state per power mode block
// Assumes: Included by the package; the design modules use its macros
// Notes:   Sizes, widths and reset values only, no logic
`ifndef PSP_DEFINES_SVH
`define PSP_DEFINES_SVH
`define PSP_NPINS      8
`define PSP_FUNC_W     3
`define PSP_PHASE_W    3
`define PSP_MODE_W     2
`define PSP_OUT_RST    1'b0
`define PSP_OE_RST     1'b0
`define PSP_IE_RST     1'b0
`define PSP_LEVEL_RST  1'b0
`endif

// ---- psp_pkg.sv ----
// Purpose: Types for the pin state per power mode block
// Assumes: psp_defines.svh holds the sizes
// Notes:   Phase and function codes are binary enums
`include "psp_defines.svh"
package psp_pkg;
  typedef enum logic [2:0] {
    PSP_PH_POR   = 3'h0,
    PSP_PH_XRST  = 3'h1,
    PSP_PH_IRST  = 3'h2,
    PSP_PH_RUN   = 3'h3,
    PSP_PH_STBY  = 3'h4
  } psp_phase_e;

  typedef enum logic [1:0] {
    PSP_SB_TIMER = 2'h0,
    PSP_SB_RTC   = 2'h1,
    PSP_SB_STOP  = 2'h2
  } psp_sbmode_e;

  typedef enum logic [2:0] {
    PSP_FN_GPIO   = 3'h0,
    PSP_FN_PERIPH = 3'h1,
    PSP_FN_OSCIN  = 3'h2,
    PSP_FN_OSCOUT = 3'h3,
    PSP_FN_EXTINT = 3'h4,
    PSP_FN_DEBUG  = 3'h5,
    PSP_FN_AIN    = 3'h6,
    PSP_FN_AOUT   = 3'h7
  } psp_func_e;

  typedef struct packed {
    psp_func_e  func;
    logic       mode_share;  // GPIO class shared with a mode input
    logic       sub_osc;     // Oscillator pin of the sub oscillator
    logic       rst_res;     // Resource drives Hi-Z/input in reset, not in power-on
  } psp_cfg_s;

  typedef struct packed {
    logic out;
    logic oe;
    logic ie;
    logic ain;
    logic pu;
  } psp_pad_s;
endpackage : psp_pkg

// ---- psp_pin_cell.sv ----
// Purpose: Pad state decision for one pin
// Assumes: Phase and standby mode come registered from the top
// Notes:   Registered outputs; hold values follow the drive in run and freeze when run ends
`timescale 1ns/10ps
`default_nettype none
module psp_pin_cell
  import psp_pkg::*;
(
  input  wire logic           i_clk_sys,
  input  wire logic           i_rst,
  input  wire psp_phase_e     i_phase,
  input  wire psp_sbmode_e    i_sbmode,
  input  wire logic           i_level_sel,
  input  wire logic           i_main_osc_run,
  input  wire logic           i_sub_osc_run,
  input  wire psp_cfg_s       i_cfg,
  input  wire logic           i_fn_out,
  input  wire logic           i_fn_oe,
  input  wire logic           i_periph_live,
  input  wire logic           i_pad_in,
  output psp_pad_s            o_pad,
  output logic                o_core_in
);
  psp_pad_s next_pad;
  logic     next_core_in;
  logic     hold_out;
  logic     hold_oe;
  logic     hold;
  logic     hiz_lo;
  logic     hiz_ie;
  logic     rst_ph;

  // Snapshot of drive while running, frozen outside run
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      hold_out <= `PSP_OUT_RST;
      hold_oe  <= `PSP_OE_RST;
    end else if (i_phase == PSP_PH_RUN) begin
      hold_out <= i_fn_out;
      hold_oe  <= i_fn_oe;
    end
  end

  assign rst_ph = (i_phase == PSP_PH_POR) || (i_phase == PSP_PH_XRST) ||
                  (i_phase == PSP_PH_IRST);

  // Decide hold, Hi-Z with input low, or Hi-Z with input live
  always_comb begin
    hold   = 1'b0;
    hiz_lo = 1'b0;
    hiz_ie = 1'b0;
    next_pad = '0;
    case (i_cfg.func)
      PSP_FN_OSCIN: begin
        hiz_ie = 1'b1; // R8
      end
      PSP_FN_OSCOUT: begin
        if (rst_ph) begin
          hiz_lo = 1'b1; // R12
        end else if (i_phase == PSP_PH_STBY &&
                     (i_cfg.sub_osc ? !i_sub_osc_run : !i_main_osc_run)) begin
          hiz_lo = 1'b1; // R10 R11
        end else begin
          hold = 1'b1;
        end
      end
      PSP_FN_AIN: begin
        hiz_lo = 1'b1; // R14
      end
      PSP_FN_AOUT: begin
        if (rst_ph) begin
          hiz_lo = 1'b1; // R17
        end else if (i_phase == PSP_PH_STBY && i_sbmode != PSP_SB_TIMER) begin
          hiz_lo = 1'b1; // R15 R16
          hold   = !i_level_sel; // Still drives with level bit 0
        end else begin
          hold = 1'b1;
        end
      end
      PSP_FN_EXTINT: begin
        if (rst_ph) hiz_lo = 1'b1; // R13 R17
        else hold = 1'b1; // R13
      end
      default: begin
        if (rst_ph) begin
          if (i_cfg.rst_res && i_phase != PSP_PH_POR) hiz_ie = 1'b1; // R18
          else hiz_lo = !i_cfg.rst_res || i_phase == PSP_PH_POR; // R17 R18
        end else if (i_phase == PSP_PH_STBY && i_level_sel &&
                     i_cfg.func != PSP_FN_DEBUG) begin // R7
          if (i_cfg.mode_share) hiz_ie = 1'b1; // R19
          else hiz_lo = 1'b1;
        end else begin
          hold = 1'b1; // R5
        end
      end
    endcase
    if (hold) begin
      next_pad.oe  = (i_phase == PSP_PH_RUN) ? i_fn_oe : hold_oe;
      next_pad.out = (i_phase == PSP_PH_RUN || i_periph_live) ? i_fn_out // R6
                                                               : hold_out; // R5
      next_pad.ie  = !hiz_lo;
    end else begin
      next_pad.oe = 1'b0; // R3
      next_pad.ie = hiz_ie;
    end
    next_pad.ain = (i_cfg.func == PSP_FN_AIN) && (i_phase != PSP_PH_POR); // R14
    next_core_in = next_pad.ie ? i_pad_in : 1'b0; // R4
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_pad     <= '0;
      o_core_in <= 1'b0;
    end else begin
      o_pad     <= next_pad;
      o_core_in <= next_core_in;
    end
  end

  // Assertions
  property p_hiz_off;
    @(posedge i_clk_sys) disable iff (i_rst)
      (i_cfg.func == PSP_FN_AIN) |=> !o_pad.oe;
  endproperty
  a_hiz_off: assert property (p_hiz_off) else $error("analog pin driven"); // R3
endmodule : psp_pin_cell
`default_nettype wire

// ---- psp_far_model.sv ----
// Purpose: Far side of the pads: board pins and oscillators
// Assumes: Standby controls come from the bench
// Notes:   Released pads toggle so a stuck input shows
`timescale 1ns/10ps
`default_nettype none
module psp_far_model
  import psp_pkg::*;
(
  input  wire logic            i_clk_sys,
  input  wire logic            i_standby_req,
  input  wire psp_sbmode_e     i_standby_mode,
  input  wire psp_pad_s [7:0]  i_pad,
  output logic [7:0]           o_pad_in,
  output logic                 o_main_osc_run,
  output logic                 o_sub_osc_run
);
  logic tog = 1'b0;
  // Free toggle, a released line never shows its last value
  always @(posedge i_clk_sys) tog <= ~tog;
  // Driven pads loop back, released ones change every cycle
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      o_pad_in[k] = i_pad[k].oe ? i_pad[k].out : tog ^ k[0];
    end
  end
  // Main stops outside timer mode, sub only in stop
  assign o_main_osc_run = !(i_standby_req && i_standby_mode != PSP_SB_TIMER);
  assign o_sub_osc_run  = !(i_standby_req && i_standby_mode == PSP_SB_STOP);
endmodule : psp_far_model
`default_nettype wire

// ---- pin_state_per_power_mode_tb_top.sv ----
// Purpose: Self-checking bench for the pad state block
// Assumes: Pin map 0 gpio/mode, 1 periph, 2 oscin, 3/4 oscout, 5 irq, 6 ain, 7 aout
// Notes:   Each phase change is given 6 edges to reach the pads
`timescale 1ns/10ps
`default_nettype none
module pin_state_per_power_mode_tb_top;
  import psp_pkg::*;
  logic           i_clk_sys, i_rst, por, xrst, irst, stby, lvl_sel, mrun, srun;
  logic           xpu, xie, xlvl, held;
  psp_sbmode_e    mode;
  psp_cfg_s [7:0] cfg;
  psp_pad_s [7:0] pad;
  psp_phase_e     phase;
  logic [7:0]     fn_out, fn_oe, live, pad_in, core_in;
  int             n_mismatch = 0;
  int             checks_done = 0;

  psp_pin_state u_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_por_active(por),
    .i_external_reset_pin(xrst), .i_int_reset(irst), .i_standby_req(stby),
    .i_standby_mode(mode), .i_standby_pin_level_select(lvl_sel), .i_main_osc_run(mrun),
    .i_sub_osc_run(srun), .i_cfg(cfg), .i_fn_out(fn_out), .i_fn_oe(fn_oe),
    .i_periph_live(live), .i_pad_in(pad_in), .o_pad(pad), .o_core_in(core_in),
    .o_xrst_pu(xpu), .o_xrst_ie(xie), .o_xrst_level(xlvl), .o_phase(phase),
    .o_level_held(held));
  psp_far_model u_far (.i_clk_sys(i_clk_sys), .i_standby_req(stby),
    .i_standby_mode(mode), .i_pad(pad), .o_pad_in(pad_in), .o_main_osc_run(mrun),
    .o_sub_osc_run(srun));

  // Clock at 100 MHz
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  // Compare selected pad fields {out,oe,ie,ain,pu}
  task automatic check_pad(input string nm, input int k, input logic [4:0] e,
                           input logic [4:0] m);
    checks_done++;
    if ((pad[k] & m) !== (e & m)) begin
      n_mismatch++;
      $display("Error %s pin %0d exp %b seen %b", nm, k, e & m, pad[k] & m);
    end
  endtask : check_pad

  task automatic check_bit(input string nm, input logic e, input logic s);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %s exp %b seen %b", nm, e, s);
    end
  endtask : check_bit

  task automatic check_phase(input psp_phase_e e);
    checks_done++;
    if (phase !== e) begin
      n_mismatch++;
      $display("Error phase exp %0d seen %0d", e, phase);
    end
  endtask : check_phase

  // Sync, phase and pad stages all need time to land
  task automatic settle();
    repeat (6) @(posedge i_clk_sys);
    #1;
  endtask : settle

  task automatic t_por();
    settle();
    check_phase(PSP_PH_POR);
    check_bit("xrst_pu", 1'b1, xpu);
    check_bit("xrst_ie", 1'b1, xie);
    check_pad("ain", 6, 5'h00, 5'h08);
    check_pad("res", 1, 5'h00, 5'h08);
    check_pad("oscin", 2, 5'h04, 5'h04);
  endtask : t_por

  task automatic t_xrst();
    @(posedge i_clk_sys);
    por <= 1'b0;
    xrst <= 1'b0;
    settle();
    check_phase(PSP_PH_XRST);
    check_bit("xrst_lvl", 1'b0, xlvl);
    check_bit("xrst_ie", 1'b1, xie);
    check_pad("res", 1, 5'h04, 5'h0c);
    check_pad("oscout", 3, 5'h00, 5'h0c);
    check_bit("osc_core", 1'b0, core_in[3]);
    check_pad("gpio", 0, 5'h00, 5'h08);
    check_pad("ain", 6, 5'h02, 5'h0e);
    check_pad("oscin", 2, 5'h04, 5'h04);
  endtask : t_xrst

  task automatic t_irst();
    @(posedge i_clk_sys);
    xrst <= 1'b1;
    irst <= 1'b1;
    settle();
    check_phase(PSP_PH_IRST);
    check_pad("oscout", 4, 5'h00, 5'h0c);
    check_pad("res", 1, 5'h04, 5'h0c);
  endtask : t_irst

  task automatic t_run();
    @(posedge i_clk_sys);
    irst <= 1'b0;
    stby <= 1'b0;
    fn_out <= 8'h03;
    settle();
    check_phase(PSP_PH_RUN);
    check_pad("gpio", 0, 5'h18, 5'h18);
    check_pad("res", 1, 5'h08, 5'h08);
    check_pad("ain", 6, 5'h02, 5'h0e);
    check_bit("ain_core", 1'b0, core_in[6]);
  endtask : t_run

  // Enter standby, mode held stable from the same edge
  task automatic enter(input psp_sbmode_e md, input logic lvl);
    @(posedge i_clk_sys);
    mode <= md;
    lvl_sel <= lvl;
    stby <= 1'b1;
    settle();
    check_phase(PSP_PH_STBY);
    check_bit("level_held", lvl, held);
  endtask : enter

  task automatic t_timer();
    enter(PSP_SB_TIMER, 1'b0);
    @(posedge i_clk_sys);
    fn_out <= 8'h00;
    settle();
    check_pad("gpio", 0, 5'h18, 5'h18);
    check_pad("res", 1, 5'h08, 5'h18);
    check_bit("gpio_core", 1'b1, core_in[0]);
    check_pad("oscout", 3, 5'h08, 5'h08);
    check_pad("aout", 7, 5'h08, 5'h08);
    t_run();
  endtask : t_timer

  task automatic t_rtc();
    enter(PSP_SB_RTC, 1'b0);
    check_pad("aout", 7, 5'h08, 5'h0c);
    check_bit("aout_core", 1'b0, core_in[7]);
    check_pad("oscout", 3, 5'h00, 5'h0c);
    check_pad("oscout", 4, 5'h08, 5'h08);
    t_run();
  endtask : t_rtc

  task automatic t_stop();
    enter(PSP_SB_STOP, 1'b1);
    check_pad("res", 1, 5'h00, 5'h0c);
    check_bit("res_core", 1'b0, core_in[1]);
    check_pad("gpio", 0, 5'h04, 5'h0c);
    check_pad("irq", 5, 5'h04, 5'h0c);
    check_pad("oscout", 4, 5'h00, 5'h0c);
    check_pad("aout", 7, 5'h00, 5'h0c);
    check_pad("oscin", 2, 5'h04, 5'h04);
    @(posedge i_clk_sys);
    lvl_sel <= 1'b0;
    settle();
    check_bit("level_held", 1'b1, held);
    t_run();
  endtask : t_stop

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  // Watchdog far beyond the fewer than a hundred cycles of the run
  initial begin
    #100000;
    n_mismatch++;
    end_of_test();
  end

  // Main sequence
  initial begin
    {i_rst, por, xrst, irst, stby, lvl_sel} = 6'b111000;
    mode = PSP_SB_TIMER;
    fn_out = 8'h00;
    fn_oe = 8'hdf;
    live = 8'h02;
    cfg = '{'{PSP_FN_AOUT, 1'b0, 1'b0, 1'b0}, '{PSP_FN_AIN, 1'b0, 1'b0, 1'b0},
            '{PSP_FN_EXTINT, 1'b0, 1'b0, 1'b0}, '{PSP_FN_OSCOUT, 1'b0, 1'b1, 1'b0},
            '{PSP_FN_OSCOUT, 1'b0, 1'b0, 1'b0}, '{PSP_FN_OSCIN, 1'b0, 1'b0, 1'b0},
            '{PSP_FN_PERIPH, 1'b0, 1'b0, 1'b1}, '{PSP_FN_GPIO, 1'b1, 1'b0, 1'b0}};
    repeat (4) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    t_por();
    t_xrst();
    t_irst();
    t_run();
    t_timer();
    t_rtc();
    t_stop();
    end_of_test();
  end
endmodule : pin_state_per_power_mode_tb_top
`default_nettype wire
